// *** design/fsc_pkg.sv ***
// constants shared by the frame-synchronised configuration shadow block
package fsc_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 11;
    localparam int IDX_W  = 9;
    localparam int GEOM_W = 7;
    localparam int GEOM_DEPTH = 96;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_MODE    = 9'h0C0;
    localparam logic [IDX_W-1:0] IDX_ROW_LEN = 9'h0C2;
    localparam logic [IDX_W-1:0] IDX_ROI_LO  = 9'h0C3;
    localparam logic [IDX_W-1:0] IDX_ROI_HI  = 9'h0C4;
    localparam logic [IDX_W-1:0] IDX_BLACK   = 9'h0C5;
    localparam logic [IDX_W-1:0] IDX_DUMMY   = 9'h0C6;
    localparam logic [IDX_W-1:0] IDX_MULT    = 9'h0C7;
    localparam logic [IDX_W-1:0] IDX_FPER    = 9'h0C8;
    localparam logic [IDX_W-1:0] IDX_EXPO    = 9'h0C9;
    localparam logic [IDX_W-1:0] IDX_GAIN    = 9'h0CC;
    localparam logic [IDX_W-1:0] IDX_SYNC    = 9'h0CE;
    localparam logic [IDX_W-1:0] IDX_STATUS  = 9'h0D0;
    localparam logic [IDX_W-1:0] IDX_GEOM_LO = 9'h100;
    localparam logic [IDX_W-1:0] IDX_GEOM_HI = 9'h15F;

    // mode register fields
    localparam int MODE_SEQ_EN   = 0;
    localparam int MODE_ROLLING  = 1;
    localparam int MODE_TRIGGER  = 4;
    localparam int MODE_SLAVE    = 5;
    localparam int MODE_EXP_SYNC = 6;
    localparam int MODE_SUBSAMP  = 7;
    localparam int MODE_BINNING  = 8;
    // freeze control fields
    localparam int SYNC_ROW_LEN  = 0;
    localparam int SYNC_BLACK    = 1;
    localparam int SYNC_DUMMY    = 2;
    localparam int SYNC_EXPOSURE = 3;
    localparam int SYNC_GAIN     = 4;
    localparam int SYNC_ROI      = 5;
    localparam int SYNC_BLANK_SW = 8;
    // gain latency compensation
    localparam int GAIN_LAT_COMP = 13;
    // status fields
    localparam int STAT_BLANK    = 0;
    localparam int STAT_ROI_SW   = 1;

    // reset values
    localparam logic [DATA_W-1:0] SYNC_RST   = 16'h003F;
    localparam logic [DATA_W-1:0] ROI_LO_RST = 16'h0001;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** design/fsc_geom_mem.sv ***
// window geometry store: one write port, two registered read ports
`timescale 1ns/10ps
`default_nettype none
module fsc_geom_mem #(
    parameter int W     = 16,
    parameter int DEPTH = 96,
    parameter int AW    = 7
) (
    input  wire logic          aclk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [AW-1:0] raddr_a,
    output logic      [W-1:0]  rdata_a,
    input  wire logic [AW-1:0] raddr_b,
    output logic      [W-1:0]  rdata_b
);
    if (DEPTH > (1 << AW)) begin : g_chk
        $error("geometry depth exceeds address range");
    end

    logic [W-1:0] mem [DEPTH];

    // write lands at once; no freeze applies here
    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_a <= mem[raddr_a];
        rdata_b <= mem[raddr_b];
    end
endmodule
`default_nettype wire

// *** design/fsc_shadow_regs.sv ***
// frame-synchronised configuration shadow registers with AXI4-Lite access
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module fsc_shadow_regs #(
    parameter int ADDR_W = fsc_pkg::ADDR_W
) (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [ADDR_W-1:0]           s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // sequencer side
    input  wire logic                        frame_start,
    input  wire logic [fsc_pkg::GEOM_W-1:0]  geom_rd_addr,
    output logic [fsc_pkg::DATA_W-1:0]       geom_rd_data,
    output logic                             seq_enable,
    output logic                             rolling_shutter,
    output logic                             triggered_mode,
    output logic                             slave_mode,
    output logic                             subsample_en,
    output logic                             binning_en,
    output logic [fsc_pkg::DATA_W-1:0]       rolling_row_length,
    output logic [fsc_pkg::DATA_W-1:0]       region_select_low_word,
    output logic [fsc_pkg::DATA_W-1:0]       region_select_high_word,
    output logic [fsc_pkg::DATA_W-1:0]       active_black_lines,
    output logic [fsc_pkg::DATA_W-1:0]       active_dummy_lines,
    output logic [fsc_pkg::DATA_W-1:0]       active_mult_timer,
    output logic [fsc_pkg::DATA_W-1:0]       frame_period_setting,
    output logic [fsc_pkg::DATA_W-1:0]       active_exposure,
    output logic [fsc_pkg::DATA_W-1:0]       active_gain,
    output logic                             blank_frame,
    output logic                             region_switch
);
    import fsc_pkg::*;

    if (ADDR_W < IDX_W + 2) begin : g_chk
        $error("address width too small for register map");
    end

    typedef logic [DATA_W-1:0] fsc_word_t;

    typedef struct packed {
        // pending copies written by software
        fsc_word_t mode;
        fsc_word_t row_len;
        fsc_word_t roi_lo;
        fsc_word_t roi_hi;
        fsc_word_t black;
        fsc_word_t dummy;
        fsc_word_t mult;
        fsc_word_t fper;
        fsc_word_t expo;
        fsc_word_t gain;
        fsc_word_t sync;
        // active copies seen by the sequencer
        fsc_word_t a_row;
        fsc_word_t a_roi_lo;
        fsc_word_t a_roi_hi;
        fsc_word_t a_black;
        fsc_word_t a_dummy;
        fsc_word_t a_mult;
        fsc_word_t a_fper;
        fsc_word_t a_expo;
        fsc_word_t a_gain;
        logic      a_sub;
        logic      a_bin;
        // one-frame staging for exposure and gain
        fsc_word_t st_mult;
        fsc_word_t st_fper;
        fsc_word_t st_expo;
        fsc_word_t st_gain;
        logic      blank;
        logic      roi_sw;
        // bus state
        logic              aw_ok;
        logic              w_ok;
        logic [IDX_W-1:0]  w_idx;
        fsc_word_t         w_data;
        logic [1:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rd_pend;
        logic [IDX_W-1:0]  r_idx;
        logic              rvalid;
        fsc_word_t         rdata;
        logic [1:0]        rresp;
    } fsc_state_t;

    fsc_state_t s;
    fsc_state_t next_s;

    logic      commit;
    logic      geom_we;
    fsc_word_t geom_bus_data;
    logic      roi_change;
    logic      exp_bypass;

    // byte-lane merge of a 16-bit register
    function automatic fsc_word_t fsc_merge(input fsc_word_t old_v, input fsc_word_t new_v,
                                            input logic [1:0] strb);
        fsc_word_t r;
        r = old_v;
        if (strb[0]) begin
            r[7:0] = new_v[7:0];
        end
        if (strb[1]) begin
            r[15:8] = new_v[15:8];
        end
        return r;
    endfunction

    // which indices answer OKAY
    function automatic logic fsc_mapped(input logic [IDX_W-1:0] idx);
        logic hit;
        hit = (idx >= IDX_GEOM_LO) && (idx <= IDX_GEOM_HI);
        unique case (idx)
            IDX_MODE, IDX_ROW_LEN, IDX_ROI_LO, IDX_ROI_HI, IDX_BLACK, IDX_DUMMY, IDX_MULT,
            IDX_FPER, IDX_EXPO, IDX_GAIN, IDX_SYNC, IDX_STATUS: hit = 1'b1;
            default: ;
        endcase
        return hit;
    endfunction

    assign commit  = s.aw_ok && s.w_ok && !s.bvalid;
    assign geom_we = commit && (s.w_idx >= IDX_GEOM_LO) && (s.w_idx <= IDX_GEOM_HI);

    // only the selection words count as a switch, geometry edits never do
    assign roi_change = (s.roi_lo != s.a_roi_lo) || (s.roi_hi != s.a_roi_hi);
    // triggered global with exposure sync mode skips the extra frame
    assign exp_bypass = s.mode[MODE_TRIGGER] && !s.mode[MODE_ROLLING]
                        && s.mode[MODE_EXP_SYNC];

    // geometry is written straight through, so no freeze reaches it
    fsc_geom_mem #(
        .W     (DATA_W),
        .DEPTH (GEOM_DEPTH),
        .AW    (GEOM_W)
    ) u_geom (
        .aclk    (aclk),
        .we      (geom_we),
        .waddr   (s.w_idx[GEOM_W-1:0]),
        .wdata   (fsc_merge(16'h0000, s.w_data, 2'h3)),
        .raddr_a (s_axi_araddr[GEOM_W+1:2]),
        .rdata_a (geom_bus_data),
        .raddr_b (geom_rd_addr),
        .rdata_b (geom_rd_data)
    );

    // next-state logic
    always_comb begin
        next_s = s;

        // frame boundary: copy pending to active per group
        if (frame_start) begin
            if (s.sync[SYNC_ROW_LEN]) begin
                next_s.a_row = s.row_len;
            end
            if (s.sync[SYNC_BLACK]) begin
                next_s.a_black = s.black;
            end
            if (s.sync[SYNC_DUMMY]) begin
                next_s.a_dummy = s.dummy;
            end
            // timer multiplier, frame period and exposure move as one
            if (s.sync[SYNC_EXPOSURE]) begin
                next_s.st_mult = s.mult;
                next_s.st_fper = s.fper;
                next_s.st_expo = s.expo;
                next_s.a_mult  = exp_bypass ? s.mult : s.st_mult;
                next_s.a_fper  = exp_bypass ? s.fper : s.st_fper;
                next_s.a_expo  = exp_bypass ? s.expo : s.st_expo;
            end
            // multiplexer and front-end gain share one word
            if (s.sync[SYNC_GAIN]) begin
                next_s.st_gain = s.gain;
                next_s.a_gain  = s.gain[GAIN_LAT_COMP] ? s.st_gain : s.gain;
            end
            // selection words with subsample and binning
            if (s.sync[SYNC_ROI]) begin
                next_s.a_roi_lo = s.roi_lo;
                next_s.a_roi_hi = s.roi_hi;
                next_s.a_sub    = s.mode[MODE_SUBSAMP];
                next_s.a_bin    = s.mode[MODE_BINNING];
            end
            next_s.roi_sw = s.sync[SYNC_ROI] && roi_change;
            // blank the starting frame while rolling reset pointers settle
            next_s.blank = s.mode[MODE_ROLLING] && (
                (s.sync[SYNC_BLACK] && (s.black != s.a_black)) ||
                (s.sync[SYNC_DUMMY] && (s.dummy != s.a_dummy)) ||
                (s.sync[SYNC_ROI] && s.sync[SYNC_BLANK_SW] && roi_change));
        end

        // write address and data are taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_ok = 1'b1;
            next_s.w_idx = s_axi_awaddr[IDX_W+1:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_ok   = 1'b1;
            next_s.w_data = s_axi_wdata[DATA_W-1:0];
            next_s.w_strb = s_axi_wstrb[1:0];
        end

        // both halves held: update pending copy, active stays until boundary
        if (commit) begin
            next_s.aw_ok  = 1'b0;
            next_s.w_ok   = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = fsc_mapped(s.w_idx) ? RESP_OKAY : RESP_SLVERR;
            unique case (s.w_idx)
                IDX_MODE:    next_s.mode    = fsc_merge(s.mode, s.w_data, s.w_strb);
                IDX_ROW_LEN: next_s.row_len = fsc_merge(s.row_len, s.w_data, s.w_strb);
                IDX_ROI_LO:  next_s.roi_lo  = fsc_merge(s.roi_lo, s.w_data, s.w_strb);
                IDX_ROI_HI:  next_s.roi_hi  = fsc_merge(s.roi_hi, s.w_data, s.w_strb);
                IDX_BLACK:   next_s.black   = fsc_merge(s.black, s.w_data, s.w_strb);
                IDX_DUMMY:   next_s.dummy   = fsc_merge(s.dummy, s.w_data, s.w_strb);
                IDX_MULT:    next_s.mult    = fsc_merge(s.mult, s.w_data, s.w_strb);
                IDX_FPER:    next_s.fper    = fsc_merge(s.fper, s.w_data, s.w_strb);
                IDX_EXPO:    next_s.expo    = fsc_merge(s.expo, s.w_data, s.w_strb);
                IDX_GAIN:    next_s.gain    = fsc_merge(s.gain, s.w_data, s.w_strb);
                IDX_SYNC:    next_s.sync    = fsc_merge(s.sync, s.w_data, s.w_strb);
                default: ;
            endcase
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // read: one cycle to let the geometry memory register its word
        if (s_axi_arvalid && s_axi_arready) begin
            next_s.rd_pend = 1'b1;
            next_s.r_idx   = s_axi_araddr[IDX_W+1:2];
        end
        if (s.rd_pend) begin
            next_s.rd_pend = 1'b0;
            next_s.rvalid  = 1'b1;
            next_s.rresp   = fsc_mapped(s.r_idx) ? RESP_OKAY : RESP_SLVERR;
            if ((s.r_idx >= IDX_GEOM_LO) && (s.r_idx <= IDX_GEOM_HI)) begin
                next_s.rdata = geom_bus_data;
            end else begin
                unique case (s.r_idx)
                    IDX_MODE:    next_s.rdata = s.mode;
                    IDX_ROW_LEN: next_s.rdata = s.row_len;
                    IDX_ROI_LO:  next_s.rdata = s.roi_lo;
                    IDX_ROI_HI:  next_s.rdata = s.roi_hi;
                    IDX_BLACK:   next_s.rdata = s.black;
                    IDX_DUMMY:   next_s.rdata = s.dummy;
                    IDX_MULT:    next_s.rdata = s.mult;
                    IDX_FPER:    next_s.rdata = s.fper;
                    IDX_EXPO:    next_s.rdata = s.expo;
                    IDX_GAIN:    next_s.rdata = s.gain;
                    IDX_SYNC:    next_s.rdata = s.sync;
                    IDX_STATUS:  next_s.rdata = {14'h0000, s.roi_sw, s.blank};
                    default:     next_s.rdata = 16'h0000;
                endcase
            end
        end
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
    end

    // state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s          <= '0;
            s.sync     <= SYNC_RST;   // all groups follow frames after reset
            s.roi_lo   <= ROI_LO_RST; // window 0 selected
            s.a_roi_lo <= ROI_LO_RST;
        end else begin
            s <= next_s;
        end
    end

    // handshakes: one write and one read in flight
    assign s_axi_awready = !s.aw_ok && !s.bvalid;
    assign s_axi_wready  = !s.w_ok && !s.bvalid;
    assign s_axi_arready = !s.rd_pend && !s.rvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rresp   = s.rresp;
    assign s_axi_rdata   = {16'h0000, s.rdata};

    // static mode bits go straight out; they are changed only while idle
    assign seq_enable      = s.mode[MODE_SEQ_EN];
    assign rolling_shutter = s.mode[MODE_ROLLING];
    assign triggered_mode  = s.mode[MODE_TRIGGER];
    assign slave_mode      = s.mode[MODE_SLAVE];

    // active set for the sequencer
    assign subsample_en            = s.a_sub;
    assign binning_en              = s.a_bin;
    assign rolling_row_length      = s.a_row;
    assign region_select_low_word  = s.a_roi_lo;
    assign region_select_high_word = s.a_roi_hi;
    assign active_black_lines      = s.a_black;
    assign active_dummy_lines      = s.a_dummy;
    assign active_mult_timer       = s.a_mult;
    assign frame_period_setting    = s.a_fper;
    assign active_exposure         = s.a_expo;
    assign active_gain             = s.a_gain;
    assign blank_frame             = s.blank;
    assign region_switch           = s.roi_sw;
endmodule
`default_nettype wire

// *** verif/fsc_shadow_regs_asserts.sv ***
// concurrent checks on the shadow register block ports
`timescale 1ns/10ps
`default_nettype none
module fsc_shadow_regs_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        frame_start,
    input wire logic        rolling_shutter,
    input wire logic        subsample_en,
    input wire logic        binning_en,
    input wire logic [15:0] region_select_low_word,
    input wire logic [15:0] active_black_lines,
    input wire logic [15:0] active_dummy_lines,
    input wire logic [15:0] active_exposure,
    input wire logic [15:0] active_gain,
    input wire logic        blank_frame
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // what the sequencer consumes; may only move after a boundary
    wire logic [82:0] act = {region_select_low_word, active_black_lines, active_dummy_lines,
                             active_exposure, active_gain, subsample_en, binning_en, blank_frame};
    // read answer comes after one internal pending cycle
    sequence s_rd_wait;
        !s_axi_rvalid ##1 s_axi_rvalid;
    endsequence
    property p_frame_hold; $past(aresetn) && !$past(frame_start) |-> $stable(act); endproperty
    property p_mode_sync; $past(aresetn) && $changed({subsample_en, binning_en}) |-> $past(frame_start); endproperty
    property p_blank_roll; $rose(blank_frame) |-> $past(frame_start) && $past(rolling_shutter); endproperty
    property p_wr_resp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
    property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_rd_wait; endproperty
    property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_frame_hold: assert property (p_frame_hold) else $error("active set moved between frames");
    a_mode_sync: assert property (p_mode_sync) else $error("subsample or binning moved mid frame");
    a_blank_roll: assert property (p_blank_roll) else $error("blank outside rolling boundary");
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");
    a_b_done: assert property (p_b_done) else $error("bvalid held after handshake");
    a_b_block: assert property (p_b_block) else $error("write taken while response open");
    a_rd_resp: assert property (p_rd_resp) else $error("read data timing wrong");
    a_r_done: assert property (p_r_done) else $error("rvalid held after handshake");
    a_r_block: assert property (p_r_block) else $error("read taken while data open");
endmodule
bind fsc_shadow_regs fsc_shadow_regs_asserts i_chk (.*);
`default_nettype wire

// *** verif/fsc_host_model.sv ***
// axi4-lite master standing in for the configuration host
`timescale 1ns/10ps
`default_nettype none
module fsc_host_model (
    input  wire logic        aclk,
    output logic [10:0]      s_axi_awaddr = 11'h000,
    output logic             s_axi_awvalid = 1'h0,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata = 32'h0,
    output logic [3:0]       s_axi_wstrb = 4'h3,
    output logic             s_axi_wvalid = 1'h0,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready = 1'h0,
    output logic [10:0]      s_axi_araddr = 11'h000,
    output logic             s_axi_arvalid = 1'h0,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready = 1'h0
);
    import fsc_pkg::*;
    // address and data offered together, each dropped once its own ready is seen
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] v, output logic [1:0] resp);
        logic pa;
        logic pw;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {16'h0000, v};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        pa = 1'h1;
        pw = 1'h1;
        while (pa || pw) begin
            @(posedge aclk);
            if (pa && s_axi_awready) pa = 1'h0;
            if (pw && s_axi_wready) pw = 1'h0;
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        while (!s_axi_bvalid) @(posedge aclk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    // one read at a time; rready stays up until data is seen
    task automatic rd(input logic [IDX_W-1:0] idx, output logic [15:0] v, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        v = s_axi_rdata[15:0];
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the shadow register block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import fsc_pkg::*;
    logic              aclk = 1'h0;
    logic              aresetn = 1'h0;
    logic              frame_start = 1'h0;
    logic [GEOM_W-1:0] geom_rd_addr = 7'h00;
    wire logic [10:0]  s_axi_awaddr, s_axi_araddr;
    wire logic [31:0]  s_axi_wdata, s_axi_rdata;
    wire logic [3:0]   s_axi_wstrb;
    wire logic [1:0]   s_axi_bresp, s_axi_rresp;
    wire logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    wire logic         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, trig, subs, binn, blank, rsw;
    wire logic [15:0]  geom_rd_data, row_len, roi_lo, roi_hi, black, dummy, expo, gain, fper;
    int                bad_count = 0;
    int                checked = 0;
    logic [15:0]       d;
    logic [1:0]        r;
    fsc_shadow_regs i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frame_start,
        .geom_rd_addr, .geom_rd_data, .seq_enable(), .rolling_shutter(), .triggered_mode(trig), .slave_mode(),
        .subsample_en(subs), .binning_en(binn), .rolling_row_length(row_len), .region_select_low_word(roi_lo),
        .region_select_high_word(roi_hi), .active_black_lines(black), .active_dummy_lines(dummy),
        .active_mult_timer(), .frame_period_setting(fper), .active_exposure(expo), .active_gain(gain),
        .blank_frame(blank), .region_switch(rsw));
    fsc_host_model i_host (.*);
    // 200 MHz clock
    always #2.5 aclk = ~aclk;
    task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic w(input logic [IDX_W-1:0] idx, input logic [15:0] v);
        i_host.wr(idx, v, r);
    endtask
    // one-cycle boundary pulse, then one edge so the new active set has landed
    task automatic frame();
        @(posedge aclk) frame_start <= 1'h1;
        @(posedge aclk) frame_start <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic t_reset();
        i_host.rd(IDX_SYNC, d, r);
        chk("sync_rst", d, SYNC_RST);
        chk("roi_lo_rst", roi_lo, ROI_LO_RST);
        i_host.rd(9'h1FF, d, r);
        chk("rd_unmapped", {14'h0, r}, {14'h0, RESP_SLVERR});
        i_host.wr(9'h1FF, 16'h1234, r);
        chk("wr_unmapped", {14'h0, r}, {14'h0, RESP_SLVERR});
    endtask
    task automatic t_sync();
        w(IDX_BLACK, 16'h0011);
        w(IDX_DUMMY, 16'h0022);
        w(IDX_FPER, 16'h0030);
        w(IDX_EXPO, 16'h0033);
        w(IDX_GAIN, 16'h0044);
        w(IDX_ROW_LEN, 16'h0055);
        chk("black_mid", black, 16'h0000);
        frame();
        chk("black", black, 16'h0011);
        chk("dummy", dummy, 16'h0022);
        chk("gain", gain, 16'h0044);
        chk("row_len", row_len, 16'h0055);
        chk("expo_lat", expo, 16'h0000);
        chk("blank_gs", {15'h0, blank}, 16'h0000);
        frame();
        chk("expo", expo, 16'h0033);
        chk("fper", fper, 16'h0030);
    endtask
    // host freezes groups around an upload
    task automatic t_freeze();
        w(IDX_SYNC, 16'h0000);
        w(IDX_BLACK, 16'h0066);
        w(IDX_GAIN, 16'h0077);
        frame();
        frame();
        chk("black_frz", black, 16'h0011);
        chk("gain_frz", gain, 16'h0044);
        w(IDX_SYNC, SYNC_RST);
        frame();
        chk("black_rel", black, 16'h0066);
        chk("gain_rel", gain, 16'h0077);
        w(IDX_SYNC, 16'h003D);
        w(IDX_BLACK, 16'h0088);
        w(IDX_DUMMY, 16'h0099);
        frame();
        chk("black_own", black, 16'h0066);
        chk("dummy_own", dummy, 16'h0099);
    endtask
    task automatic t_blank();
        w(IDX_MODE, 16'h0002);
        w(IDX_SYNC, SYNC_RST);
        frame();
        chk("blank_black", {15'h0, blank}, 16'h0001);
        i_host.rd(IDX_STATUS, d, r);
        chk("status", d, 16'h0001);
        frame();
        chk("blank_once", {15'h0, blank}, 16'h0000);
        w(IDX_DUMMY, 16'h00AA);
        frame();
        chk("blank_dummy", {15'h0, blank}, 16'h0001);
        w(IDX_ROI_LO, 16'h0002);
        frame();
        chk("blank_noopt", {15'h0, blank}, 16'h0000);
        chk("roi_sw", {15'h0, rsw}, 16'h0001);
        chk("roi_lo", roi_lo, 16'h0002);
        w(IDX_SYNC, 16'h013F);
        w(IDX_ROI_HI, 16'h0001);
        frame();
        chk("blank_opt", {15'h0, blank}, 16'h0001);
        chk("roi_hi", roi_hi, 16'h0001);
        w(IDX_ROI_LO, 16'h0002);
        frame();
        chk("roi_same", {15'h0, rsw}, 16'h0000);
        w(IDX_MODE, 16'h0000);
        w(IDX_BLACK, 16'h00BB);
        frame();
        chk("blank_global", {15'h0, blank}, 16'h0000);
    endtask
    // triggered global with exposure sync, plus subsample and binning
    task automatic t_mode();
        w(IDX_MODE, 16'h01D0);
        w(IDX_EXPO, 16'h00CC);
        chk("subs_mid", {15'h0, subs}, 16'h0000);
        chk("trig", {15'h0, trig}, 16'h0001);
        frame();
        chk("subs_bin", {14'h0, subs, binn}, 16'h0003);
        chk("expo_sync", expo, 16'h00CC);
        w(IDX_GAIN, 16'h2005);
        frame();
        chk("gain_lat", gain, 16'h0077);
        frame();
        chk("gain_comp", gain, 16'h2005);
    endtask
    // geometry writes go through even with the region group frozen
    task automatic t_geom();
        w(IDX_SYNC, 16'h0000);
        w(9'h105, 16'h1234);
        geom_rd_addr <= 7'h05;
        @(posedge aclk);
        @(posedge aclk);
        chk("geom", geom_rd_data, 16'h1234);
        i_host.rd(9'h105, d, r);
        chk("geom_rd", d, 16'h1234);
        chk("roi_keep", roi_lo, 16'h0002);
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_sync();
        t_freeze();
        t_blank();
        t_mode();
        t_geom();
        end_of_test();
    end
    // about twenty times the expected run length
    initial begin
        #20000;
        bad_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
